/* rtl/gpio_modem_pin_port_consts.svh */
/*
 holds every offset and field position of the pin port, and the reset values of its four software registers, as macros.
 assumes it is included by its bare name from the package and the port module.
*/
`ifndef GPIO_MODEM_PIN_PORT_CONSTS_SVH
`define GPIO_MODEM_PIN_PORT_CONSTS_SVH

// ==========================================================
// register indices on the register access port
`define OFS_RX_FIFO_FILL_LEVEL    3'h0
`define OFS_PIN_DIRECTION         3'h1
`define OFS_PIN_LEVEL             3'h2
`define OFS_PIN_CHANGE_IRQ_ENABLE 3'h3
`define OFS_PIN_FUNCTION_CONTROL  3'h4

// ==========================================================
// pin function control fields
`define CTRL_SOFT_RESET_BIT       3
`define CTRL_MODEM_CHAN_B_BIT     2
`define CTRL_MODEM_CHAN_A_BIT     1
`define CTRL_INPUT_LATCH_BIT      0

// ==========================================================
// reset values
`define RST_PIN_DIRECTION         8'h00
`define RST_PIN_LEVEL             8'h00
`define RST_PIN_CHANGE_IRQ_ENABLE 8'h00
`define RST_PIN_FUNCTION_CONTROL  3'h0

// ==========================================================
// position of each modem line inside its nibble
`define NIB_RING_BIT              3
`define NIB_CARRIER_BIT           2
`define NIB_TERM_READY_BIT        1
`define NIB_SET_READY_BIT         0

// ==========================================================
// receive fill level
`define FILL_MAX                  64
`define FILL_W                    7

`endif

/* rtl/gpio_modem_pin_port_pkg.sv */
/*
 holds the types shared by the pin port and its surroundings.
 assumes the constants header sits beside it.
*/
`include "gpio_modem_pin_port_consts.svh"

package gpio_modem_pin_port_pkg;

   // ==========================================================
   // register access request, one cycle per strobe
   typedef struct packed {
      logic [2:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_req_t;

   // ==========================================================
   // modem view of one channel, as the status register sees it
   typedef struct packed {
      logic carrier;
      logic ring;
      logic set_ready;
      logic carrier_chg;
      logic ring_chg;
      logic set_ready_chg;
   } modem_status_t;

endpackage : gpio_modem_pin_port_pkg

/* rtl/gpio_modem_pin_port.sv */
/*
 holds the eight-pin general purpose port with its modem-line takeover and the
 receive fill level readout. assumes a host interface that presents one
 register access per cycle, a uart core that supplies the fill count, the
 modem interrupt enable and terminal-ready control bits and a status read strobe per
 channel, and pads that resolve pin_out/pin_oe_n into a wire.
*/
`timescale 1ns/1ps

`include "gpio_modem_pin_port_consts.svh"

module gpio_modem_pin_port
   import gpio_modem_pin_port_pkg::*;
#(
   parameter int PINS = 8
)
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire reg_req_t            reg_req,
   output logic [7:0]               reg_rdata,
   input  wire logic [`FILL_W-1:0]  rx_fill_count,
   input  wire logic [PINS-1:0]     pin_in,
   output logic [PINS-1:0]          pin_out,
   output logic [PINS-1:0]          pin_oe_n,
   input  wire logic [1:0]          modem_irq_enable,
   input  wire logic [1:0]          term_ready_ctrl,
   input  wire logic [1:0]          modem_status_read,
   output modem_status_t            modem_status_chan_a,
   output modem_status_t            modem_status_chan_b,
   input  wire logic                other_irq,
   output logic                     irq,
   output logic                     soft_reset_pulse
);

   // ==========================================================
   // elaboration check
   if (PINS != 8)
   begin : g_bad_pins
      $error("the nibble takeover logic serves exactly eight pins");
   end

   // ==========================================================
   // register decode
   logic                wr_dir;
   logic                wr_lvl;
   logic                wr_ien;
   logic                wr_ctrl;
   logic                rd_lvl;

   assign wr_dir  = reg_req.wr && (reg_req.addr == `OFS_PIN_DIRECTION);
   assign wr_lvl  = reg_req.wr && (reg_req.addr == `OFS_PIN_LEVEL);
   assign wr_ien  = reg_req.wr && (reg_req.addr == `OFS_PIN_CHANGE_IRQ_ENABLE);
   assign wr_ctrl = reg_req.wr && (reg_req.addr == `OFS_PIN_FUNCTION_CONTROL);
   assign rd_lvl  = reg_req.rd && (reg_req.addr == `OFS_PIN_LEVEL);

   // ==========================================================
   // software reset: one-cycle pulse clears the software registers, the pin change tracking and the modem change bits
   logic                srst_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         srst_q <= 1'b0;
      else
         srst_q <= wr_ctrl && reg_req.wdata[`CTRL_SOFT_RESET_BIT];
   end

   assign soft_reset_pulse = srst_q;

   // ==========================================================
   // software registers
   logic [PINS-1:0]     dir_q;
   logic [PINS-1:0]     lvl_wr_q;
   logic [PINS-1:0]     ien_q;
   logic [2:0]          ctrl_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dir_q    <= `RST_PIN_DIRECTION;
         lvl_wr_q <= `RST_PIN_LEVEL;
         ien_q    <= `RST_PIN_CHANGE_IRQ_ENABLE;
         ctrl_q   <= `RST_PIN_FUNCTION_CONTROL;
      end
      else if (srst_q)
      begin
         dir_q    <= `RST_PIN_DIRECTION;
         lvl_wr_q <= `RST_PIN_LEVEL;
         ien_q    <= `RST_PIN_CHANGE_IRQ_ENABLE;
         ctrl_q   <= `RST_PIN_FUNCTION_CONTROL;
      end
      else
      begin
         if (wr_dir)
            dir_q <= reg_req.wdata;
         if (wr_lvl)
            lvl_wr_q <= reg_req.wdata;
         if (wr_ien)
            ien_q <= reg_req.wdata;
         // the reset bit and bits 7:4 are never stored
         if (wr_ctrl)
            ctrl_q <= reg_req.wdata[2:0];
      end
   end

   // ==========================================================
   // nibble ownership
   logic                modem_a;
   logic                modem_b;
   logic                latch_on;
   logic [PINS-1:0]     modem_pin;

   assign modem_a   = ctrl_q[`CTRL_MODEM_CHAN_A_BIT];
   assign modem_b   = ctrl_q[`CTRL_MODEM_CHAN_B_BIT];
   assign latch_on  = ctrl_q[`CTRL_INPUT_LATCH_BIT];
   assign modem_pin = {{4{modem_a}}, {4{modem_b}}};

   // ==========================================================
   // per-pin change tracking
   logic [PINS-1:0]     ref_q;
   logic [PINS-1:0]     hold_q;
   logic [PINS-1:0]     cap_q;
   logic [PINS-1:0]     level_view;
   logic [PINS-1:0]     pin_pend;
   logic                primed_q;   // reset cannot see the pins, so references load on the first edge

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         primed_q <= 1'b0;
      else
         primed_q <= 1'b1;
   end

   for (genvar i = 0; i < PINS; i++)
   begin : g_pin
      logic watched;
      logic changed;

      // only gpio inputs take part; modem pins and outputs are ignored
      assign watched = !modem_pin[i] && !dir_q[i];
      assign changed = watched && (pin_in[i] != ref_q[i]);

      // a latched bit shows the level that caused the interrupt
      assign level_view[i] = (latch_on && hold_q[i]) ? cap_q[i] : pin_in[i];

      // unlatched pending follows the pin, so a return clears it
      assign pin_pend[i] = ien_q[i] && (latch_on ? hold_q[i] : changed);

      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            ref_q[i]  <= 1'b0;
            hold_q[i] <= 1'b0;
            cap_q[i]  <= 1'b0;
         end
         else if (srst_q || !watched || !primed_q)
         begin
            ref_q[i]  <= pin_in[i];
            hold_q[i] <= 1'b0;
            cap_q[i]  <= pin_in[i];
         end
         else if (rd_lvl)
         begin
            // reference is what software saw; a change in the read cycle
            // still differs from it and fires again, so it is not lost
            ref_q[i]  <= level_view[i];
            hold_q[i] <= latch_on && changed && !hold_q[i];
            cap_q[i]  <= pin_in[i];
         end
         else if (latch_on && changed && !hold_q[i])
         begin
            hold_q[i] <= 1'b1;
            cap_q[i]  <= pin_in[i];
         end
         else if (!latch_on)
            hold_q[i] <= 1'b0;
      end
   end

   // ==========================================================
   // pin drive
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_out  <= '0;
         pin_oe_n <= '1;
      end
      else
      begin
         for (int i = 0; i < PINS; i++)
         begin
            pin_out[i]  <= lvl_wr_q[i];
            pin_oe_n[i] <= !dir_q[i];
         end
         // modem nibbles: terminal-ready pin is driven, the rest are inputs
         if (modem_a)
         begin
            pin_oe_n[7:4]                    <= 4'hD;
            pin_out[4 + `NIB_TERM_READY_BIT] <= !term_ready_ctrl[0];
         end
         if (modem_b)
         begin
            pin_oe_n[3:0]                    <= 4'hD;
            pin_out[`NIB_TERM_READY_BIT]     <= !term_ready_ctrl[1];
         end
      end
   end

   // ==========================================================
   // modem line status, one channel per nibble
   logic [PINS-1:0]     prev_q;
   logic [2:0]          chg_a_q;
   logic [2:0]          chg_b_q;
   logic [2:0]          ev_a;
   logic [2:0]          ev_b;

   // events ordered carrier, ring, set-ready; ring counts a low-to-high pin edge
   function automatic logic [2:0] line_events(input logic [3:0] now, input logic [3:0] was);
      line_events = {now[`NIB_CARRIER_BIT] ^ was[`NIB_CARRIER_BIT],
                     now[`NIB_RING_BIT] && !was[`NIB_RING_BIT],
                     now[`NIB_SET_READY_BIT] ^ was[`NIB_SET_READY_BIT]};
   endfunction : line_events

   assign ev_a = line_events(pin_in[7:4], prev_q[7:4]);
   assign ev_b = line_events(pin_in[3:0], prev_q[3:0]);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         prev_q <= '1;
      else
         prev_q <= pin_in;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         chg_a_q <= 3'h0;
         chg_b_q <= 3'h0;
      end
      else if (srst_q)
      begin
         chg_a_q <= 3'h0;
         chg_b_q <= 3'h0;
      end
      else
      begin
         // a new event in the read cycle survives the clear
         if (!modem_a)
            chg_a_q <= 3'h0;
         else
            chg_a_q <= (modem_status_read[0] ? 3'h0 : chg_a_q) | ev_a;
         if (!modem_b)
            chg_b_q <= 3'h0;
         else
            chg_b_q <= (modem_status_read[1] ? 3'h0 : chg_b_q) | ev_b;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         modem_status_chan_a <= '0;
         modem_status_chan_b <= '0;
      end
      else
      begin
         // lines are active low; status shows the complement, or zero in io mode
         modem_status_chan_a <= modem_a ?
            {!pin_in[4 + `NIB_CARRIER_BIT], !pin_in[4 + `NIB_RING_BIT],
             !pin_in[4 + `NIB_SET_READY_BIT], chg_a_q} : '0;
         modem_status_chan_b <= modem_b ?
            {!pin_in[`NIB_CARRIER_BIT], !pin_in[`NIB_RING_BIT],
             !pin_in[`NIB_SET_READY_BIT], chg_b_q} : '0;
      end
   end

   // ==========================================================
   // shared interrupt
   logic                modem_pend;

   assign modem_pend = (modem_a && modem_irq_enable[0] && (|chg_a_q))
                    || (modem_b && modem_irq_enable[1] && (|chg_b_q));

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         irq <= 1'b0;
      else
         irq <= (|pin_pend) || modem_pend || other_irq;
   end

   // ==========================================================
   // read data
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else if (reg_req.rd)
      begin
         case (reg_req.addr)
            `OFS_RX_FIFO_FILL_LEVEL:    reg_rdata <= {1'b0, rx_fill_count};
            `OFS_PIN_DIRECTION:         reg_rdata <= dir_q;
            `OFS_PIN_LEVEL:             reg_rdata <= level_view;
            `OFS_PIN_CHANGE_IRQ_ENABLE: reg_rdata <= ien_q;
            `OFS_PIN_FUNCTION_CONTROL:  reg_rdata <= {5'h00, ctrl_q};
            default:                    reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule : gpio_modem_pin_port

/* bench/gpio_modem_pin_port_chk.sv */
/* checker of the pin port, watching its ports only.
   assumes one clock with an async active-low reset. */
`timescale 1ns/1ps
`include "gpio_modem_pin_port_consts.svh"
module gpio_modem_pin_port_chk
   import gpio_modem_pin_port_pkg::*;
#(
   parameter int PINS = 8
)
(
   input wire logic               clk,
   input wire logic               arst_n,
   input wire reg_req_t           reg_req,
   input wire logic [7:0]         reg_rdata,
   input wire logic [`FILL_W-1:0] rx_fill_count,
   input wire logic [PINS-1:0]    pin_in,
   input wire logic [PINS-1:0]    pin_out,
   input wire logic [PINS-1:0]    pin_oe_n,
   input wire logic [1:0]         modem_irq_enable,
   input wire logic [1:0]         term_ready_ctrl,
   input wire logic [1:0]         modem_status_read,
   input wire modem_status_t      modem_status_chan_a,
   input wire modem_status_t      modem_status_chan_b,
   input wire logic               other_irq,
   input wire logic               irq,
   input wire logic               soft_reset_pulse
);
   // ==========================================================
   // nibble modes shadowed from writes; soft reset drops them too
   logic [2:1] mode_q;
   wire        wr_ctrl = reg_req.wr && reg_req.addr == `OFS_PIN_FUNCTION_CONTROL;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         mode_q <= 2'h0;
      else if (soft_reset_pulse)
         mode_q <= 2'h0;
      else if (wr_ctrl)
         mode_q <= reg_req.wdata[2:1];
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // three cycles, since status and pins lag the mode by one register
   sequence io_a;
      !mode_q[1] [*3];
   endsequence
   sequence io_b;
      !mode_q[2] [*3];
   endsequence
   sequence modem_a;
      mode_q[1] [*3];
   endsequence
   // ==========================================================
   // assertions
   a_fill_read: assert property (
      reg_req.rd && reg_req.addr == `OFS_RX_FIFO_FILL_LEVEL |=> reg_rdata == {1'h0, $past(rx_fill_count)})
      else $error("fill level read wrong");
   a_soft_pulse: assert property (
      wr_ctrl && reg_req.wdata[`CTRL_SOFT_RESET_BIT] |=> soft_reset_pulse ##1 !soft_reset_pulse)
      else $error("soft reset pulse wrong");
   a_dir_input: assert property (
      reg_req.wr && reg_req.addr == `OFS_PIN_DIRECTION && reg_req.wdata == 8'h00 ##1 !reg_req.wr
      |=> (pin_oe_n | 8'h22) == 8'hFF)
      else $error("input pin still driven");
   a_other_irq: assert property (other_irq |=> irq)
      else $error("shared irq missing");
   a_io_quiet_a: assert property (io_a |-> modem_status_chan_a == '0)
      else $error("status a in io mode");
   a_io_quiet_b: assert property (io_b |-> modem_status_chan_b == '0)
      else $error("status b in io mode");
   a_modem_dir: assert property (modem_a |-> pin_oe_n[7] && pin_oe_n[6] && pin_oe_n[4] && !pin_oe_n[5])
      else $error("modem pin direction wrong");
   a_term_drive: assert property (modem_a |-> pin_out[5] == !$past(term_ready_ctrl[0]))
      else $error("terminal ready level wrong");
   a_modem_irq: assert property (
      (|modem_status_chan_a[2:0]) && $past(modem_irq_enable[0]) |-> irq)
      else $error("modem irq missing");
endmodule : gpio_modem_pin_port_chk

bind gpio_modem_pin_port gpio_modem_pin_port_chk #(.PINS(PINS)) u_chk (.clk, .arst_n, .reg_req, .reg_rdata,
   .rx_fill_count, .pin_in, .pin_out, .pin_oe_n, .modem_irq_enable, .term_ready_ctrl, .modem_status_read,
   .modem_status_chan_a, .modem_status_chan_b, .other_irq, .irq, .soft_reset_pulse);

/* bench/pin_partner.sv */
/* peripherals on the pins: they drive every pin the port leaves undriven.
   assumes pin_oe_n low means the port drives. */
`timescale 1ns/1ps
module pin_partner #(
   parameter int PINS = 8
)
(
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe_n,
   input wire logic [PINS-1:0] ext_lvl,
   output logic [PINS-1:0]     pin_in
);
   // ==========================================================
   // wire level: port wins where it drives
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule : pin_partner

/* bench/tb.sv */
/* self-checking bench of the pin port.
   assumes the checker is bound and the partner model is compiled. */
`timescale 1ns/1ps
`include "gpio_modem_pin_port_consts.svh"
module tb
   import gpio_modem_pin_port_pkg::*;
;
   logic          clk, arst_n, oirq, irq, srp;
   reg_req_t      req;
   logic [7:0]    rdata, pout, oe_n, pin_in, ext;
   logic [6:0]    fill;
   logic [1:0]    mien, trc, st_rd;
   modem_status_t sa, sb;
   int            n_fail, comparisons;
   gpio_modem_pin_port u_dut (.clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
      .rx_fill_count(fill), .pin_in(pin_in), .pin_out(pout), .pin_oe_n(oe_n), .modem_irq_enable(mien),
      .term_ready_ctrl(trc), .modem_status_read(st_rd), .modem_status_chan_a(sa), .modem_status_chan_b(sb),
      .other_irq(oirq), .irq(irq), .soft_reset_pulse(srp));
   pin_partner u_pins (.pin_out(pout), .pin_oe_n(oe_n), .ext_lvl(ext), .pin_in(pin_in));
   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one-cycle access strobe
   task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk);
      req <= '0;
      #1;
   endtask : acc
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      acc(a, 1'h0, 8'h00);
      chk(rdata, e);
   endtask : rd
   task automatic setp(input logic [7:0] v, input int n);
      @(posedge clk);
      ext <= v;
      cyc(n);
   endtask : setp
   task automatic clr_status;
      @(posedge clk);
      st_rd <= 2'h1;
      @(posedge clk);
      st_rd <= 2'h0;
      cyc(2);
   endtask : clr_status
   // ==========================================================
   // scenarios
   task automatic t_fill(input logic [6:0] f);
      @(posedge clk);
      fill <= f;
      rd(`OFS_RX_FIFO_FILL_LEVEL, {1'h0, f});
   endtask : t_fill
   task automatic t_pins;
      acc(`OFS_PIN_DIRECTION, 1'h1, 8'h0F);
      acc(`OFS_PIN_LEVEL, 1'h1, 8'hA5);
      setp(8'h3C, 2);
      chk(oe_n, 8'hF0);
      chk(pout & 8'h0F, 8'h05);
      rd(`OFS_PIN_LEVEL, 8'h35);
      acc(`OFS_PIN_DIRECTION, 1'h1, 8'h00);
   endtask : t_pins
   task automatic t_modem;
      setp(8'hFF, 2);
      rd(`OFS_PIN_LEVEL, 8'hFF);
      acc(`OFS_PIN_CHANGE_IRQ_ENABLE, 1'h1, 8'hFF);
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'h02);
      cyc(3);
      clr_status();
      chk(sa, 8'h00);
      setp(8'hBF, 3);
      chk(sa, 8'h24);
      chk(irq, 8'h00);
      @(posedge clk);
      mien <= 2'h1;
      cyc(2);
      chk(irq, 8'h01);
      setp(8'h2F, 3);
      chk(sa, 8'h3D);
      setp(8'hAF, 3);
      chk(sa, 8'h2F);
      @(posedge clk);
      trc <= 2'h3;
      cyc(2);
      chk(pin_in & 8'h22, 8'h02);
      chk(sb, 8'h00);
      clr_status();
      cyc(1);
      chk(irq, 8'h00);
      @(posedge clk);
      mien <= 2'h0;
      trc <= 2'h0;
      acc(`OFS_PIN_CHANGE_IRQ_ENABLE, 1'h1, 8'h00);
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'h00);
   endtask : t_modem
   task automatic t_modem_b;
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'h04);
      cyc(3);
      chk(oe_n, 8'hFD);
      setp(8'hFB, 3);
      chk(sb, 8'h24);
      chk(sa, 8'h00);
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'h00);
   endtask : t_modem_b
   task automatic t_other;
      @(posedge clk);
      oirq <= 1'h1;
      cyc(2);
      chk(irq, 8'h01);
      @(posedge clk);
      oirq <= 1'h0;
      cyc(2);
      chk(irq, 8'h00);
   endtask : t_other
   task automatic t_irq;
      setp(8'h3C, 2);
      rd(`OFS_PIN_LEVEL, 8'h3C);
      acc(`OFS_PIN_CHANGE_IRQ_ENABLE, 1'h1, 8'h01);
      setp(8'h3D, 2);
      chk(irq, 8'h01);
      setp(8'h3C, 2);
      chk(irq, 8'h00);
      setp(8'h3E, 2);
      chk(irq, 8'h00);
      setp(8'h3F, 2);
      rd(`OFS_PIN_LEVEL, 8'h3F);
      cyc(1);
      chk(irq, 8'h00);
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'h01);
      setp(8'h3E, 2);
      chk(irq, 8'h01);
      setp(8'h3F, 2);
      chk(irq, 8'h01);
      rd(`OFS_PIN_LEVEL, 8'h3E);
   endtask : t_irq
   task automatic t_soft;
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'hF1);
      rd(`OFS_PIN_FUNCTION_CONTROL, 8'h01);
      rd(3'h7, 8'h00);
      acc(`OFS_PIN_DIRECTION, 1'h1, 8'h81);
      acc(`OFS_PIN_FUNCTION_CONTROL, 1'h1, 8'h08);
      cyc(3);
      rd(`OFS_PIN_FUNCTION_CONTROL, 8'h00);
      rd(`OFS_PIN_DIRECTION, 8'h00);
   endtask : t_soft
   task automatic conclude;
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // ==========================================================
   // clock, sequence and watchdog
   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      {arst_n, oirq, mien, trc, st_rd, fill} = '0;
      req = '0;
      ext = 8'hFF;
      n_fail = 0;
      comparisons = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'h1;
      t_fill(7'h00);
      t_fill(7'h40);
      t_pins();
      t_modem();
      t_modem_b();
      t_other();
      t_irq();
      t_soft();
      conclude();
   end
   // the tests take well under a thousand cycles
   initial
   begin
      #20000;
      n_fail++;
      conclude();
   end
endmodule : tb
